// File: bbr_pkg.sv
// Package for the buck/boost supply controller: register map, fields, modes, timing.
// Assumes a 32-bit Avalon-MM slave with word-aligned byte addresses.
package bbr_pkg;

   // System operating modes as driven by the mode manager
   typedef enum logic [2:0] {
      BBR_MODE_NORMAL  = 3'h0,
      BBR_MODE_STOP    = 3'h1,
      BBR_MODE_RESTART = 3'h2,
      BBR_MODE_SLEEP   = 3'h3,
      BBR_MODE_FAILSAFE= 3'h4
   } bbr_mode_t;

   // Register byte offsets
   localparam logic [3:0] BBR_HARDWARE_CONTROL_REG_OFS   = 4'h0;
   localparam logic [3:0] BBR_SUPPLY_ST_OFS = 4'h4;
   localparam logic [3:0] BBR_WAKE_ST_OFS   = 4'h8;
   localparam logic [3:0] BBR_MODE_CMD_OFS  = 4'hC;

   // Hardware control fields
   localparam int BBR_HC_BOOST_EN  = 0;
   localparam int BBR_HC_LOW_SEL   = 1;
   localparam int BBR_HC_HIGH_SEL  = 2;
   localparam int BBR_HC_AUTO_PWM  = 3;
   localparam int BBR_HC_WAKE_MOD  = 4;
   localparam logic [4:0] BBR_HC_RESET = 5'h08;

   // Supply status fields
   localparam int BBR_SS_SW_OPEN  = 0;
   localparam int BBR_SS_SW_SHORT = 1;
   localparam int BBR_SS_OUT_WIN  = 2;
   localparam int BBR_SS_STEP_UP_ACTIVE_FLAG  = 3;

   // Wake status field
   localparam int BBR_WS_TRANS = 0;

   // Soft start shaping
   localparam int         BBR_DUTY_W      = 8;
   localparam logic [7:0] BBR_SS_MIN_DUTY = 8'h10;
   localparam logic [7:0] BBR_SS_STEP     = 8'h08;
   localparam int         BBR_SS_PERIODS  = 4;
   localparam int         BBR_PERIOD_NS   = 2000;
   localparam int         BBR_CLK_NS      = 40;
   localparam int         BBR_PERIOD_CYC  = BBR_PERIOD_NS / BBR_CLK_NS;

   // Edge shaping dead time between switches
   localparam int BBR_DEAD_NS  = 80;
   localparam int BBR_DEAD_CYC = (BBR_DEAD_NS + BBR_CLK_NS - 1) / BBR_CLK_NS;

endpackage

// File: bbr_gate_seq.sv
// Non-overlapping high/low switch sequencer with dead time.
// Assumes a synchronous PWM request from the controller.
`timescale 1ns/1ps
`default_nettype none
module bbr_gate_seq
   import bbr_pkg::*;
#(
   parameter int DEAD = BBR_DEAD_CYC
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Request
   input  wire logic on_req,
   input  wire logic enable,
   // Gate drives
   output var  logic hs_on,
   output var  logic ls_on
);
   logic [7:0] dead_r;
   wire        dead_done = (dead_r == 8'h00);

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hs_on  <= 1'b0;
         ls_on  <= 1'b0;
         dead_r <= 8'h00;
      end else if (!enable) begin
         hs_on  <= 1'b0;
         ls_on  <= 1'b0;
         dead_r <= 8'h00;
      end else if (on_req != hs_on && (on_req ? ls_on : 1'b1)) begin
         // Break before make
         if (on_req) begin
            ls_on  <= 1'b0;
            dead_r <= 8'(DEAD);
         end else begin
            hs_on  <= 1'b0;
            dead_r <= 8'(DEAD);
         end
      end else if (!dead_done) begin
         dead_r <= dead_r - 8'h01;
      end else begin
         hs_on <= on_req;
         ls_on <= !on_req;
      end
   end
endmodule
`default_nettype wire

// File: bbr_top.sv
// Buck/boost supply controller: mode enables, modulation, soft start, status.
// Assumes synchronous bus, asynchronous comparators, mode from system manager.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bbr_top
   import bbr_pkg::*;
#(
   parameter int PERIOD   = BBR_PERIOD_CYC,
   parameter int SS_HOLD  = BBR_SS_PERIODS
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   // System mode
   input  wire logic [2:0]  sys_mode,
   // Analog comparators (asynchronous)
   input  wire logic        cmp_out_low,
   input  wire logic        cmp_out_target,
   input  wire logic        cmp_in_low,
   input  wire logic        cmp_load_high,
   input  wire logic        cmp_sw_open,
   input  wire logic        cmp_sw_short,
   input  wire logic        cmp_out_window,
   input  wire logic        cmp_vs_below_th1,
   input  wire logic        cmp_vs_above_hys1,
   input  wire logic        cmp_vs_below_th2,
   input  wire logic        cmp_vs_above_hys2,
   input  wire logic        wake_input_pin,
   // Analog stage controls
   output var  logic        buck_enable,
   output var  logic        buck_pwm_mode,
   output var  logic        buck_hs_on,
   output var  logic        buck_ls_on,
   output var  logic [7:0]  buck_duty,
   output var  logic        boost_enable,
   output var  logic        boost_switching,
   output var  logic        step_up_high_level_select,
   output var  logic        boost_low_level,
   output var  logic        trans_event
);
   localparam int NS = 11;

   // Two-flop synchronisers
   logic [NS-1:0] s1_r;
   logic [NS-1:0] s2_r;
   wire  [NS-1:0] async_in = {wake_input_pin, cmp_vs_above_hys2, cmp_vs_below_th2,
                              cmp_vs_above_hys1, cmp_vs_below_th1, cmp_out_window,
                              cmp_sw_short, cmp_sw_open, cmp_load_high, cmp_in_low,
                              cmp_out_low};
   genvar g;
   generate
      for (g = 0; g < NS; g++) begin : g_sync
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               s1_r[g] <= 1'b0;
               s2_r[g] <= 1'b0;
            end else begin
               s1_r[g] <= async_in[g];
               s2_r[g] <= s1_r[g];
            end
         end
      end
   endgenerate

   wire out_low   = s2_r[0];
   wire in_low    = s2_r[1];
   wire load_high = s2_r[2];
   wire sw_open   = s2_r[3];
   wire sw_short  = s2_r[4];
   wire out_win   = s2_r[5];
   wire below_th1 = s2_r[6];
   wire above_h1  = s2_r[7];
   wire below_th2 = s2_r[8];
   wire above_h2  = s2_r[9];
   wire wake_lvl  = s2_r[10];

   // Registers
   logic [4:0] hardware_control_reg;
   logic [3:0] supply_status_reg;
   logic [0:0] wake_status_reg;
   logic [2:0] mode_r;
   logic       trans_r;
   logic       boost_sw_r;
   logic       ss_active_r;
   logic       ss_pending_r;
   logic [7:0] duty_r;
   logic [7:0] per_cnt_r;
   logic [7:0] hold_cnt_r;
   logic       read_done_r;

   // Mode decode
   wire mode_norm  = (sys_mode == 3'(BBR_MODE_NORMAL));
   wire mode_stop  = (sys_mode == 3'(BBR_MODE_STOP));
   wire mode_rst   = (sys_mode == 3'(BBR_MODE_RESTART));
   wire smps_on    = mode_norm | mode_stop | mode_rst;
   wire enter_stop = mode_stop && (mode_r != 3'(BBR_MODE_STOP));
   wire from_off   = (mode_r == 3'(BBR_MODE_SLEEP)) || (mode_r == 3'(BBR_MODE_FAILSAFE));
   wire ss_trigger = mode_rst && from_off;

   // Config fields
   wire cfg_boost_en = hardware_control_reg[BBR_HC_BOOST_EN];
   wire cfg_low_sel  = hardware_control_reg[BBR_HC_LOW_SEL];
   wire cfg_high_sel = hardware_control_reg[BBR_HC_HIGH_SEL];
   wire cfg_auto     = hardware_control_reg[BBR_HC_AUTO_PWM];
   wire cfg_wake_mod = hardware_control_reg[BBR_HC_WAKE_MOD];

   // Boost threshold selection
   wire sel_below = cfg_low_sel ? below_th1 : below_th2;
   wire sel_above = cfg_low_sel ? above_h1  : above_h2;
   wire boost_ok  = cfg_boost_en && (mode_norm || mode_stop);
   wire boost_run = (boost_ok || (mode_rst && cfg_boost_en)) && smps_on;
   wire boost_nxt = !boost_run ? 1'b0 :
                    sel_below  ? 1'b1 :
                    sel_above  ? 1'b0 : boost_sw_r;

   // Stop-mode modulation
   wire auto_hit   = mode_stop && cfg_auto && !cfg_wake_mod && load_high && !trans_r;
   wire stop_cmd   = avs_write && !avs_waitrequest && (avs_address == BBR_MODE_CMD_OFS)
                     && avs_byteenable[0] && (avs_writedata[2:0] == 3'(BBR_MODE_STOP));
   wire stop_pwm   = cfg_wake_mod ? wake_lvl : trans_r;
   wire pwm_sel    = mode_norm || mode_rst || (mode_stop && stop_pwm);

   // Soft start: one tick per switching period
   wire per_tick = (per_cnt_r == 8'(PERIOD - 1));
   wire hold_end = (hold_cnt_r == 8'(SS_HOLD - 1));

   // Duty from regulation comparators
   wire [7:0] duty_reg  = in_low ? 8'hFF :
                          out_low ? ((duty_r > 8'hEF) ? 8'hFF : duty_r + 8'h10) :
                          (duty_r < 8'h10) ? 8'h00 : duty_r - 8'h10;
   // Buck switch request: PWM comparison or frequency pulses on demand
   wire pwm_on   = (duty_r == 8'hFF) || (per_cnt_r < duty_r);
   wire buck_req = pwm_sel ? pwm_on : out_low;

   // Bus decode
   wire sel_hc = (avs_address == BBR_HARDWARE_CONTROL_REG_OFS);
   wire sel_ss = (avs_address == BBR_SUPPLY_ST_OFS);
   wire sel_ws = (avs_address == BBR_WAKE_ST_OFS);
   wire wr_acc = avs_write && !avs_waitrequest;
   wire bst_clr_try = wr_acc && sel_ss && avs_byteenable[0] && avs_writedata[BBR_SS_STEP_UP_ACTIVE_FLAG];
   wire bst_clr_ok  = bst_clr_try && !sel_below;
   wire [31:0] rd_mux = sel_hc ? {27'h0, hardware_control_reg} :
                        sel_ss ? {28'h0, supply_status_reg} :
                        sel_ws ? {31'h0, wake_status_reg} :
                        (avs_address == BBR_MODE_CMD_OFS) ? {29'h0, mode_r} : 32'h0;

   // Bus slave: one wait cycle per access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
         read_done_r     <= 1'b0;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest && !read_done_r);
         read_done_r     <= (avs_read || avs_write) && avs_waitrequest && !read_done_r;
         if (avs_read && avs_waitrequest)
            avs_readdata <= rd_mux;
      end
   end

   // Configuration register
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         hardware_control_reg <= BBR_HC_RESET;
      else if (wr_acc && sel_hc && avs_byteenable[0])
         hardware_control_reg <= avs_writedata[4:0];
   end

   // Status flags, set wins over clear; no side effects
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_status_reg <= 4'h0;
         wake_status_reg   <= 1'b0;
      end else begin
         supply_status_reg[BBR_SS_SW_OPEN] <= sw_open ||
            (supply_status_reg[BBR_SS_SW_OPEN] &&
             !(wr_acc && sel_ss && avs_byteenable[0] && avs_writedata[BBR_SS_SW_OPEN]));
         supply_status_reg[BBR_SS_SW_SHORT] <= sw_short ||
            (supply_status_reg[BBR_SS_SW_SHORT] &&
             !(wr_acc && sel_ss && avs_byteenable[0] && avs_writedata[BBR_SS_SW_SHORT]));
         supply_status_reg[BBR_SS_OUT_WIN] <= (out_win && smps_on) ||
            (supply_status_reg[BBR_SS_OUT_WIN] &&
             !(wr_acc && sel_ss && avs_byteenable[0] && avs_writedata[BBR_SS_OUT_WIN]));
         supply_status_reg[BBR_SS_STEP_UP_ACTIVE_FLAG] <= (boost_nxt && !boost_sw_r) ||
            (supply_status_reg[BBR_SS_STEP_UP_ACTIVE_FLAG] && !bst_clr_ok);
         wake_status_reg[BBR_WS_TRANS] <= auto_hit ||
            (wake_status_reg[BBR_WS_TRANS] &&
             !(wr_acc && sel_ws && avs_byteenable[0] && avs_writedata[BBR_WS_TRANS]));
      end
   end

   // Mode tracking, transition state, boost state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r      <= 3'(BBR_MODE_SLEEP);
         trans_r     <= 1'b0;
         trans_event <= 1'b0;
         boost_sw_r  <= 1'b0;
      end else begin
         mode_r      <= sys_mode;
         trans_event <= auto_hit;
         boost_sw_r  <= boost_nxt;
         if (enter_stop || !mode_stop)
            trans_r <= 1'b0;
         else if (auto_hit)
            trans_r <= 1'b1;
         else if (stop_cmd && !load_high)
            trans_r <= 1'b0;
      end
   end

   // Soft start sequencer and duty loop
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ss_pending_r <= 1'b1;
         ss_active_r  <= 1'b0;
         duty_r       <= 8'h00;
         per_cnt_r    <= 8'h00;
         hold_cnt_r   <= 8'h00;
      end else begin
         per_cnt_r <= per_tick ? 8'h00 : per_cnt_r + 8'h01;
         if (!smps_on) begin
            duty_r       <= 8'h00;
            ss_active_r  <= 1'b0;
            ss_pending_r <= ss_pending_r;
         end else if (ss_pending_r || ss_trigger) begin
            ss_pending_r <= 1'b0;
            ss_active_r  <= 1'b1;
            duty_r       <= BBR_SS_MIN_DUTY;
            hold_cnt_r   <= 8'h00;
         end else if (ss_active_r && per_tick) begin
            if (!out_low) begin
               ss_active_r <= 1'b0;
            end else if (hold_end) begin
               hold_cnt_r <= 8'h00;
               duty_r     <= (duty_r > 8'hFF - BBR_SS_STEP) ? 8'hFF : duty_r + BBR_SS_STEP;
            end else begin
               hold_cnt_r <= hold_cnt_r + 8'h01;
            end
         end else if (!ss_active_r && per_tick && pwm_sel) begin
            duty_r <= duty_reg;
         end
      end
   end

   // Stage outputs
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         buck_enable               <= 1'b0;
         buck_pwm_mode             <= 1'b0;
         buck_duty                 <= 8'h00;
         boost_enable              <= 1'b0;
         boost_switching           <= 1'b0;
         step_up_high_level_select <= 1'b0;
         boost_low_level           <= 1'b0;
      end else begin
         buck_enable               <= smps_on;
         buck_pwm_mode             <= pwm_sel;
         buck_duty                 <= duty_r;
         boost_enable              <= boost_run;
         boost_switching           <= boost_nxt;
         step_up_high_level_select <= cfg_high_sel && !cfg_low_sel;
         boost_low_level           <= cfg_low_sel;
      end
   end

   // Buck switch sequencing
   bbr_gate_seq #(
      .DEAD (BBR_DEAD_CYC)
   ) u_gate (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .on_req  (buck_req),
      .enable  (buck_enable),
      .hs_on   (buck_hs_on),
      .ls_on   (buck_ls_on)
   );
endmodule
`default_nettype wire

// File: bbr_analog_model.sv
// Behavioural power stage, comparators and supply sense for the controller.
// Assumes the bench sets supply level, load and fault requests.
`timescale 1ns/1ps
`default_nettype none
module bbr_analog_model
   import bbr_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Bench controls
   input  wire logic [7:0] vs_lvl,
   input  wire logic       load_req,
   input  wire logic [2:0] fault_req,
   // Gate drives from the controller
   input  wire logic       buck_enable,
   input  wire logic       buck_hs_on,
   input  wire logic       buck_ls_on,
   // Comparator outputs
   output logic            cmp_out_low,
   output logic            cmp_in_low,
   output logic            cmp_load_high,
   output logic            cmp_sw_open,
   output logic            cmp_sw_short,
   output logic            cmp_out_window,
   output logic            cmp_vs_below_th1,
   output logic            cmp_vs_above_hys1,
   output logic            cmp_vs_below_th2,
   output logic            cmp_vs_above_hys2
);
   logic [7:0] vout_r;
   // Output rises while high side conducts, falls while low side conducts
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n || !buck_enable) vout_r <= 8'h00;
      else if (buck_hs_on && vout_r != 8'hFF) vout_r <= vout_r + 8'h01;
      else if (buck_ls_on && vout_r != 8'h00) vout_r <= vout_r - 8'h01;
   end
   assign cmp_out_low       = vout_r < 8'h80;
   assign cmp_in_low        = vs_lvl < 8'h14;
   assign cmp_load_high     = load_req;
   assign {cmp_out_window, cmp_sw_short, cmp_sw_open} = fault_req;
   // Threshold pairs: first 0x28 and 0x32, second 0x3C and 0x4B
   assign cmp_vs_below_th1  = vs_lvl < 8'h28;
   assign cmp_vs_above_hys1 = vs_lvl > 8'h32;
   assign cmp_vs_below_th2  = vs_lvl < 8'h3C;
   assign cmp_vs_above_hys2 = vs_lvl > 8'h4B;
endmodule
`default_nettype wire

// File: bbr_assertions.sv
// Port checker for the supply controller.
// Assumes binding into bbr_top with one clock domain.
`timescale 1ns/1ps
`default_nettype none
module bbr_assertions
   import bbr_pkg::*;
#(
   parameter int PERIOD  = BBR_PERIOD_CYC,
   parameter int SS_HOLD = BBR_SS_PERIODS
) (
   // Clock and reset
   input wire logic       sys_clk,
   input wire logic       rst_n,
   // Watched inputs
   input wire logic [2:0] sys_mode,
   input wire logic       cmp_load_high,
   input wire logic       wake_input_pin,
   input wire logic       cmp_vs_below_th1,
   input wire logic       cmp_vs_above_hys1,
   input wire logic       cmp_vs_below_th2,
   // Watched outputs
   input wire logic       buck_enable,
   input wire logic       buck_pwm_mode,
   input wire logic       buck_hs_on,
   input wire logic       buck_ls_on,
   input wire logic       boost_enable,
   input wire logic       boost_switching,
   input wire logic       boost_low_level,
   input wire logic       trans_event
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire off_m  = sys_mode == BBR_MODE_SLEEP || sys_mode == BBR_MODE_FAILSAFE;
   wire pwm_m  = sys_mode == BBR_MODE_NORMAL || sys_mode == BBR_MODE_RESTART;
   wire stop_q = sys_mode == BBR_MODE_STOP && !cmp_load_high && !wake_input_pin;
   wire lo_on  = boost_enable && boost_low_level && cmp_vs_below_th1;
   wire hi_on  = boost_enable && !boost_low_level && cmp_vs_below_th2;
   property p_off; off_m[*4] |-> !buck_enable && !boost_enable; endproperty
   a_off: assert property (p_off) else $error("Stage on in off mode");
   property p_on; (pwm_m || sys_mode == BBR_MODE_STOP)[*6] |-> buck_enable; endproperty
   a_on: assert property (p_on) else $error("Buck off in active mode");
   property p_pwm; pwm_m[*6] |-> buck_pwm_mode; endproperty
   a_pwm: assert property (p_pwm) else $error("Buck not in width mode");
   property p_pfm;
      ($past(sys_mode) != BBR_MODE_STOP && !$past(cmp_load_high)) ##0 stop_q[*6]
         |-> !buck_pwm_mode;
   endproperty
   a_pfm: assert property (p_pfm) else $error("Stop entry kept width mode");
   property p_ovl; !(buck_hs_on && buck_ls_on); endproperty
   a_ovl: assert property (p_ovl) else $error("Both buck switches on");
   property p_dead; $fell(buck_hs_on) |-> !buck_ls_on[*2]; endproperty
   a_dead: assert property (p_dead) else $error("Dead time too short");
   property p_trans;
      trans_event |-> $past(sys_mode) == BBR_MODE_STOP ##1 !trans_event;
   endproperty
   a_trans: assert property (p_trans) else $error("Bad transition pulse");
   property p_b1on; lo_on[*6] |-> boost_switching; endproperty
   a_b1on: assert property (p_b1on) else $error("Boost idle below first level");
   property p_b1off; (boost_low_level && cmp_vs_above_hys1)[*6] |-> !boost_switching;
   endproperty
   a_b1off: assert property (p_b1off) else $error("Boost on above hysteresis");
   property p_b2on; hi_on[*6] |-> boost_switching; endproperty
   a_b2on: assert property (p_b2on) else $error("Boost idle below second level");
   property p_bsw; boost_switching |-> boost_enable; endproperty
   a_bsw: assert property (p_bsw) else $error("Boost switching while off");
   c_trans: cover property (trans_event);
   c_bst: cover property ($rose(boost_switching));
   c_pfm: cover property ($fell(buck_pwm_mode));
endmodule
bind bbr_top bbr_assertions #(.PERIOD(PERIOD), .SS_HOLD(SS_HOLD)) u_chk (
   .sys_clk, .rst_n, .sys_mode, .cmp_load_high, .wake_input_pin, .cmp_vs_below_th1,
   .cmp_vs_above_hys1, .cmp_vs_below_th2, .buck_enable, .buck_pwm_mode, .buck_hs_on,
   .buck_ls_on, .boost_enable, .boost_switching, .boost_low_level, .trans_event);
`default_nettype wire

// File: tb_buck_boost_regulator_control.sv
// Self-checking bench for the supply controller with analog model.
// Assumes short soft start parameters and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_buck_boost_regulator_control
   import bbr_pkg::*;
();
   localparam int PER = 10;
   localparam int HLD = 2;
   localparam int LAT = 10;
   logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, wake_input_pin, load_req;
   logic buck_enable, buck_pwm_mode, buck_hs_on, buck_ls_on, boost_enable, boost_switching;
   logic step_up_high_level_select, boost_low_level, trans_event, cmp_out_target;
   logic cmp_out_low, cmp_in_low, cmp_load_high, cmp_sw_open, cmp_sw_short, cmp_out_window;
   logic cmp_vs_below_th1, cmp_vs_above_hys1, cmp_vs_below_th2, cmp_vs_above_hys2;
   logic [3:0]  avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rd, st;
   logic [7:0]  buck_duty, vs_lvl;
   logic [2:0]  sys_mode, fault_req;
   int          bad_count, cmp_count, n, i, t0;
   int          cyc = 0;
   int          trans_n = 0;
   bbr_top #(.PERIOD(PER), .SS_HOLD(HLD)) dut (.sys_clk, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .sys_mode, .cmp_out_low, .cmp_out_target, .cmp_in_low, .cmp_load_high, .cmp_sw_open,
      .cmp_sw_short, .cmp_out_window, .cmp_vs_below_th1, .cmp_vs_above_hys1,
      .cmp_vs_below_th2, .cmp_vs_above_hys2, .wake_input_pin, .buck_enable, .buck_pwm_mode,
      .buck_hs_on, .buck_ls_on, .buck_duty, .boost_enable, .boost_switching,
      .step_up_high_level_select, .boost_low_level, .trans_event);
   bbr_analog_model u_ana (.sys_clk, .rst_n, .vs_lvl, .load_req, .fault_req, .buck_enable,
      .buck_hs_on, .buck_ls_on, .cmp_out_low, .cmp_in_low, .cmp_load_high, .cmp_sw_open,
      .cmp_sw_short, .cmp_out_window, .cmp_vs_below_th1, .cmp_vs_above_hys1,
      .cmp_vs_below_th2, .cmp_vs_above_hys2);
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (trans_event === 1'b1) trans_n <= trans_n + 1;
      if (cyc == 40000) begin
         bad_count = bad_count + 1;
         give_verdict();
      end
   end
   function automatic logic [31:0] rnd();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction
   // Control word: wake select, auto, high, low, enable
   function automatic logic [31:0] hc(input logic w, a, h, l, e);
      return {27'h0, w, a, h, l, e};
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      // Wait for the answer; only the cycle ceiling ends a hang
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic w(input int c);
      repeat (c) @(posedge sys_clk);
   endtask
   task automatic sst_start(); // Wait for first soft start duty
      for (n = 0; n < 300 && buck_duty === 8'h00; n++) @(posedge sys_clk);
      chk(buck_duty, BBR_SS_MIN_DUTY);
   endtask
   initial begin
      {avs_read, avs_write, wake_input_pin, load_req, cmp_out_target} = 5'h00;
      {avs_address, avs_writedata, fault_req} = '0;
      {bad_count, cmp_count} = '0;
      avs_byteenable = 4'hF;
      sys_mode = BBR_MODE_SLEEP;
      vs_lvl = 8'h80;
      st = 32'h9530;
      rst_n = 1'b0;
      w(20);
      rst_n <= 1'b1;
      rdc(BBR_HARDWARE_CONTROL_REG_OFS, {27'h0, BBR_HC_RESET});
      rdc(BBR_SUPPLY_ST_OFS, 32'h0);
      rdc(4'h2, 32'h0);
      chk(buck_enable, 1'b0);
      sys_mode <= BBR_MODE_NORMAL;
      sst_start();
      t0 = cyc;
      for (n = 0; n < 4 * PER * HLD && buck_duty === BBR_SS_MIN_DUTY; n++) w(1);
      chk(buck_duty, BBR_SS_MIN_DUTY + BBR_SS_STEP);
      chk(cyc - t0 >= PER * HLD - 4, 1'b1);
      w(1500);
      chk(buck_pwm_mode, 1'b1);
      vs_lvl <= 8'h0A;
      w(LAT + PER);
      chk(buck_hs_on, 1'b1);
      w(PER);
      chk(buck_hs_on, 1'b1);
      vs_lvl <= 8'h80;
      i = rnd() & 1;
      bus(1'b1, BBR_HARDWARE_CONTROL_REG_OFS, hc(0, 1, i[0], 1, 1));
      vs_lvl <= 8'h1E + 8'(rnd() & 32'h7);
      w(LAT);
      chk({boost_low_level, step_up_high_level_select}, 2'h2);
      chk(boost_switching, 1'b1);
      bus(1'b1, BBR_SUPPLY_ST_OFS, 32'h8);
      rdc(BBR_SUPPLY_ST_OFS, 32'h8);
      vs_lvl <= 8'h37;
      w(LAT);
      chk(boost_switching, 1'b0);
      bus(1'b1, BBR_SUPPLY_ST_OFS, 32'h8);
      rdc(BBR_SUPPLY_ST_OFS, 32'h0);
      bus(1'b1, BBR_HARDWARE_CONTROL_REG_OFS, hc(0, 1, 1, 0, 1));
      vs_lvl <= 8'h2D + 8'(rnd() & 32'h7);
      w(LAT);
      chk({boost_low_level, step_up_high_level_select, boost_switching}, 3'h3);
      vs_lvl <= 8'h44;
      w(LAT);
      chk(boost_switching, 1'b1);
      vs_lvl <= 8'h80;
      w(LAT);
      chk(boost_switching, 1'b0);
      bus(1'b1, BBR_SUPPLY_ST_OFS, 32'hF);
      for (i = 0; i < 3; i++) begin
         fault_req <= 3'h1 << i;
         w(LAT);
         rdc(BBR_SUPPLY_ST_OFS, 32'h1 << i);
         chk({buck_enable, buck_pwm_mode}, 2'h3);
         rdc(BBR_HARDWARE_CONTROL_REG_OFS, hc(0, 1, 1, 0, 1));
         fault_req <= 3'h0;
         w(LAT);
         bus(1'b1, BBR_SUPPLY_ST_OFS, 32'h7);
      end
      bus(1'b1, BBR_HARDWARE_CONTROL_REG_OFS, {27'h0, BBR_HC_RESET});
      sys_mode <= BBR_MODE_STOP;
      w(LAT);
      chk(buck_pwm_mode, 1'b0);
      rdc(BBR_MODE_CMD_OFS, {29'h0, BBR_MODE_STOP});
      n = trans_n;
      load_req <= 1'b1;
      w(LAT);
      chk({buck_pwm_mode, trans_n == n + 1}, 2'h3);
      rdc(BBR_WAKE_ST_OFS, 32'h1);
      bus(1'b1, BBR_MODE_CMD_OFS, 32'h1);
      w(LAT);
      chk(buck_pwm_mode, 1'b1);
      load_req <= 1'b0;
      w(LAT);
      bus(1'b1, BBR_MODE_CMD_OFS, 32'h1);
      w(LAT);
      chk(buck_pwm_mode, 1'b0);
      bus(1'b1, BBR_WAKE_ST_OFS, 32'h1);
      rdc(BBR_WAKE_ST_OFS, 32'h0);
      bus(1'b1, BBR_HARDWARE_CONTROL_REG_OFS, 32'h0);
      n = trans_n;
      load_req <= 1'b1;
      w(LAT);
      chk({buck_pwm_mode, trans_n == n}, 2'h1);
      load_req <= 1'b0;
      bus(1'b1, BBR_HARDWARE_CONTROL_REG_OFS, hc(1, 0, 0, 0, 0));
      for (i = 0; i < 4; i++) begin
         wake_input_pin <= 1'(rnd());
         w(LAT);
         chk(buck_pwm_mode, wake_input_pin);
      end
      sys_mode <= BBR_MODE_FAILSAFE;
      w(LAT);
      chk({buck_enable, boost_enable}, 2'h0);
      sys_mode <= BBR_MODE_RESTART;
      sst_start();
      give_verdict();
   end
endmodule
`default_nettype wire
